//--- dv/mpwm_gate_model.sv
// Purpose: gate driver side of the bridge, counts gate high cycles and rises
// Assumes: an undriven gate input is pulled low
// Notes: also makes the external pwm clock, held low while not asked for
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_gate_model (
    // control
    input wire logic clock_i,
    input wire logic clear_i,
    input wire logic ext_run_i,
    // gates
    input wire logic [`MPWM_NCH-1:0] pin_default_i,
    input wire logic [`MPWM_NCH-1:0] pin_default_oe_i,
    input wire logic [`MPWM_NSHARE-1:0] pin_alt_i,
    input wire logic [`MPWM_NSHARE-1:0] pin_alt_oe_i,
    // results
    output logic ext_clk_o,
    output logic [15:0] high_cnt_o [`MPWM_NCH],
    output logic [15:0] rise_cnt_o [`MPWM_NCH]
);
    logic [`MPWM_NCH-1:0] gate, prev;
    always_comb begin
        gate = pin_default_i & pin_default_oe_i;
        for (int c = 0; c < `MPWM_NSHARE; c++) begin
            if (pin_alt_oe_i[c]) begin
                gate[c] = pin_alt_i[c];
            end
        end
    end
    always @(posedge clock_i) begin
        prev <= gate;
        for (int c = 0; c < `MPWM_NCH; c++) begin
            high_cnt_o[c] <= clear_i ? 16'h0 : high_cnt_o[c] + {15'h0, gate[c]};
            rise_cnt_o[c] <= clear_i ? 16'h0 : rise_cnt_o[c] + {15'h0, gate[c] & ~prev[c]};
        end
    end
    initial begin
        ext_clk_o = 1'b0;
        #3;
        forever #10 ext_clk_o = ext_run_i ? ~ext_clk_o : 1'b0;
    end
endmodule

//--- dv/mpwm_properties.sv
// Purpose: port properties of the pwm top
// Assumes: one clock domain
// Notes: pins lag the enables by a clock, so the idle check waits two
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_properties (
    // bus
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // pins
    input wire logic [`MPWM_NCH-1:0] pin_default_o,
    input wire logic [`MPWM_NCH-1:0] pin_default_oe_o,
    input wire logic [`MPWM_NSHARE-1:0] pin_alt_o,
    input wire logic [`MPWM_NSHARE-1:0] pin_alt_oe_o,
    input wire logic [`MPWM_NCH-1:0] chan_running_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    wire take = hsel_i && hready_i && htrans_i[1] && hreadyout_o;
    sequence s_wait1; !hreadyout_o ##1 hreadyout_o; endsequence
    sequence s_idle2; (chan_running_o == '0) [*2]; endsequence
    property p_rd_wait; take && !hwrite_i |=> s_wait1; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read lacks its one wait state");
    property p_wr_fast; take && hwrite_i |=> hreadyout_o; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write data phase stalled");
    property p_low_cause; !hreadyout_o |-> $past(take) && !$past(hwrite_i); endproperty
    a_low_cause: assert property (p_low_cause) else $error("stall without a read");
    property p_okay; hresp_o == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_gate; (pin_default_oe_o & ~chan_running_o) == '0 && (pin_alt_oe_o & ~chan_running_o[7:0]) == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("pin driven by a stopped channel");
    property p_reloc; (pin_default_oe_o[7:0] ^ pin_alt_oe_o) == chan_running_o[7:0]; endproperty
    a_reloc: assert property (p_reloc) else $error("shared channel not on exactly one pin");
    property p_upper; pin_default_oe_o[15:8] == chan_running_o[15:8]; endproperty
    a_upper: assert property (p_upper) else $error("upper channel pin enable wrong");
    property p_idle; s_idle2 |-> pin_default_o == '0 && pin_alt_o == '0; endproperty
    a_idle: assert property (p_idle) else $error("pin high with no channel running");
endmodule
bind mpwm_top mpwm_properties u_props (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .pin_default_o(pin_default_o), .pin_default_oe_o(pin_default_oe_o), .pin_alt_o(pin_alt_o),
    .pin_alt_oe_o(pin_alt_oe_o), .chan_running_o(chan_running_o));

//--- dv/multichannel_pwm_with_sync_bench.sv
// Purpose: self-checking bench of the pwm block
// Assumes: peripheral and external sources tick every other clock
// Notes: windows span whole periods, or half a period of identical slots on the slower sources, so start phase does not matter
`timescale 1ns/1ps
`include "mpwm_map.svh"
module multichannel_pwm_with_sync_bench;
    logic clock_i = 1'b0, rstn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, ptick = 1'b0;
    logic trun = 1'b0, erun = 1'b0, clr = 1'b0, eclk, rdy, resp;
    logic [31:0] haddr = 32'h0, wdata = 32'h0, rdata;
    logic [1:0] htrans = 2'h0;
    logic [`MPWM_NCH-1:0] pd, pd_oe, run;
    logic [`MPWM_NSHARE-1:0] pa, pa_oe;
    logic [15:0] hi [`MPWM_NCH];
    logic [15:0] ri [`MPWM_NCH];
    int err_count = 0, checked = 0;
    mpwm_top u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(wdata), .hready_i(rdy), .hrdata_o(rdata),
        .hreadyout_o(rdy), .hresp_o(resp), .periph_tick_i(ptick), .ext_clk_i(eclk), .pin_default_o(pd),
        .pin_default_oe_o(pd_oe), .pin_alt_o(pa), .pin_alt_oe_o(pa_oe), .chan_running_o(run));
    mpwm_gate_model u_gate (.clock_i(clock_i), .clear_i(clr), .ext_run_i(erun), .pin_default_i(pd),
        .pin_default_oe_i(pd_oe), .pin_alt_i(pa), .pin_alt_oe_i(pa_oe), .ext_clk_o(eclk), .high_cnt_o(hi),
        .rise_cnt_o(ri));
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        ptick <= trun & ~ptick;
    end
    task automatic stop_test();
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock_i);
        {hsel_i, htrans, hwrite_i, haddr} <= {1'b1, 2'h2, wr, 20'h0, a};
        do @(posedge clock_i); while (rdy !== 1'b1);
        {hsel_i, htrans, wdata} <= {1'b0, 2'h0, d};
        do @(posedge clock_i); while (rdy !== 1'b1);
        q = rdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp(q, exp);
    endtask
    function automatic logic [11:0] ca(input int ch, input logic [3:0] f);
        return `MPWM_OFF_CH_BASE + 12'(ch * 16) + {8'h0, f};
    endfunction
    task automatic chan(input int ch, input logic [31:0] c, input logic [31:0] d, input logic [31:0] dl);
        wr(ca(ch, `MPWM_CH_CFG), c);
        wr(ca(ch, `MPWM_CH_DUTY), d);
        wr(ca(ch, `MPWM_CH_DELAY), dl);
    endtask
    task automatic meas(input int ch, input int n, input logic [15:0] eh, input logic [15:0] er);
        @(posedge clock_i);
        clr <= 1'b1;
        @(posedge clock_i);
        clr <= 1'b0;
        repeat (n) @(posedge clock_i);
        #1;
        cmp({hi[ch], ri[ch]}, {eh, er});
    endtask
    task automatic t_regs();
        rd(`MPWM_OFF_STAT, 32'h0);
        rd(ca(7, `MPWM_CH_SPREAD), 32'h20);
        wr(ca(7, `MPWM_CH_SPREAD), 32'h5);
        rd(ca(7, `MPWM_CH_SPREAD), 32'h20);
        wr(ca(7, `MPWM_CH_SPREAD), 32'h4);
        rd(ca(7, `MPWM_CH_SPREAD), 32'h4);
        wr(ca(7, `MPWM_CH_SPREAD), 32'h20);
        rd(ca(7, `MPWM_CH_SPREAD), 32'h20);
        rd(12'h300, 32'h0);
    endtask
    task automatic t_gate();
        chan(7, 32'h1, 32'd2048, 32'd64);
        chan(9, 32'h1, 32'd2048 - 32'd640, 32'd74);
        meas(7, 64, 16'd0, 16'd0);
        wr(`MPWM_OFF_CTRL, 32'h3);
        rd(`MPWM_OFF_STAT, 32'h280);
        meas(7, 4096, 16'd2048, 16'd32);
        cmp({16'h0, hi[9]}, 32'd1408);
    endtask
    task automatic t_update();
        wr(ca(7, `MPWM_CH_DUTY), 32'd2560);
        wr(ca(9, `MPWM_CH_DUTY), 32'd1920);
        meas(7, 4096, 16'd2048, 16'd32);
        wr(`MPWM_OFF_CTRL, 32'h3);
        rd(`MPWM_OFF_CTRL, 32'h1);
        meas(7, 4096, 16'd2560, 16'd32);
        cmp({16'h0, hi[9]}, 32'd1920);
    endtask
    task automatic t_pins();
        wr(ca(9, `MPWM_CH_CFG), 32'h3);
        meas(9, 4096, 16'd2176, 16'd32);
        wr(ca(7, `MPWM_CH_CFG), 32'h5);
        #1;
        cmp({pd_oe[7], pa_oe[7]}, 32'h1);
        meas(7, 4096, 16'd2560, 16'd32);
        wr(ca(9, `MPWM_CH_SPREAD), 32'h4);
        chan(9, 32'h1, 32'd1001, 32'd0);
        wr(`MPWM_OFF_CTRL, 32'h3);
        meas(9, 4096, 16'd1001, 16'd4);
    endtask
    task automatic t_clock();
        trun <= 1'b1;
        wr(ca(7, `MPWM_CH_CFG), 32'h11);
        meas(7, 4096, 16'd2560, 16'd16);
        {trun, erun} <= 2'b01;
        wr(ca(7, `MPWM_CH_CFG), 32'h21);
        meas(7, 4096, 16'd2560, 16'd16);
        erun <= 1'b0;
        // source code 3 gives no ticks, so a restarted counter stays frozen
        wr(ca(7, `MPWM_CH_CFG), 32'h31);
        wr(`MPWM_OFF_SYNC, 32'h80);
        meas(7, 4096, 16'd4096, 16'd0);
    endtask
    task automatic t_sync();
        int bad;
        bad = 0;
        chan(0, 32'h1, 32'd2048, 32'd0);
        chan(4, 32'h1, 32'd4096 - 32'd2048, 32'd64);
        wr(`MPWM_OFF_CTRL, 32'h3);
        wr(`MPWM_OFF_SYNC, 32'h11);
        repeat (4) @(posedge clock_i);
        repeat (256) begin
            @(posedge clock_i);
            bad += int'(pd[0] === pd[4]);
        end
        cmp(32'(bad), 32'h0);
        rd(`MPWM_OFF_SYNC, 32'h11);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_regs();
        t_gate();
        t_update();
        t_pins();
        t_clock();
        t_sync();
        stop_test();
    end
    initial begin
        #1000000;
        err_count++;
        stop_test();
    end
endmodule

//--- rtl/mpwm_map.svh
// Purpose: constants of the multichannel pwm block with synchronised restart
// Assumes: one 100 MHz clock, pwm ticks derived from the selected source
// Notes: byte offsets on the ahb-lite register bus
// Overview of operation
// RL1: 12-bit resolution gives a 4096-tick base period; duty and delay in ticks.
// RL2: 32-slot spreading splits the period in 32 slots; 781.25kHz at 100MHz.
// RL3: spreading setting accepts 4 or 32 per channel.
// RL4: clock source code 0 core, 1 peripheral, 2 external input.
// RL5: polarity 0 passes the waveform, 1 inverts it.
// RL6: channels 0 to 7 use dac-shared pins unless relocate bit moves them.
// RL7: channel runs only with its own enable and the master enable set.
// RL8: software sets master enable only after configuring all channels.
// RL9: written duty stays pending until the global update bit is set.
// RL10: update applies all pending duties at once, then self-clears after one clock.
// RL11: restart mask register restarts all selected channels together in phase.
// RL12: per-channel delay in ticks shifts the waveform from the restart reference.
// RL13: duty counts ticks; 2048 is half of the 4096-tick period.
// RL14: software sets second high-side duty to period minus first high-side duty.
// RL15: software sets low-side duty to high-side duty minus 32 times twice dead time.
// RL16: software sets low-side delay to high-side delay plus dead time.
// RL17: delay counts from the latest synchronised restart of the channel.
`ifndef MPWM_MAP_SVH
`define MPWM_MAP_SVH

`define MPWM_NCH 16
`define MPWM_NSHARE 8
`define MPWM_CNT_W 12
`define MPWM_DUTY_W 13
`define MPWM_PERIOD 4096
`define MPWM_CLK_MHZ 100

// register offsets
`define MPWM_OFF_CTRL 12'h000
`define MPWM_OFF_SYNC 12'h004
`define MPWM_OFF_STAT 12'h008
`define MPWM_OFF_CH_BASE 12'h100
`define MPWM_OFF_CH_END 12'h200
`define MPWM_CH_CFG 4'h0
`define MPWM_CH_DUTY 4'h4
`define MPWM_CH_DELAY 4'h8
`define MPWM_CH_SPREAD 4'hC

// field positions
`define MPWM_CTRL_MEN 0
`define MPWM_CTRL_UPD 1
`define MPWM_CFG_EN 0
`define MPWM_CFG_INV 1
`define MPWM_CFG_RELOC 2
`define MPWM_CFG_CLK_LO 4
`define MPWM_CFG_CLK_HI 5

// codes
`define MPWM_CLK_CORE 2'h0
`define MPWM_CLK_PERIPH 2'h1
`define MPWM_CLK_EXT 2'h2
`define MPWM_SPREAD_4 6'h04
`define MPWM_SPREAD_32 6'h20

// reset values
`define MPWM_RST_S32 1'b1
`define MPWM_RST_DUTY 13'h0000
`define MPWM_RST_DELAY 12'h000

`endif

//--- rtl/mpwm_pkg.sv
// Purpose: types of the multichannel pwm block
// Assumes: constants come from mpwm_map.svh
// Notes: all module state is one packed struct
`include "mpwm_map.svh"
package mpwm_pkg;

    typedef struct packed {
        logic en;
        logic inv;
        logic reloc;
        logic s32;
        logic [1:0] clksel;
    } mpwm_cfg_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hsel;
        logic hready;
    } mpwm_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } mpwm_ahb_rsp_t;

    typedef struct packed {
        logic master_en;
        logic upd;
        logic [`MPWM_NCH-1:0] sync_mask;
        mpwm_cfg_t [`MPWM_NCH-1:0] cfg;
        logic [`MPWM_NCH-1:0][`MPWM_DUTY_W-1:0] duty_pend;
        logic [`MPWM_NCH-1:0][`MPWM_DUTY_W-1:0] duty_act;
        logic [`MPWM_NCH-1:0][`MPWM_CNT_W-1:0] dly;
        logic [`MPWM_NCH-1:0][`MPWM_CNT_W-1:0] cnt;
        logic [`MPWM_NCH-1:0] pin_def;
        logic [`MPWM_NSHARE-1:0] pin_alt;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic dp_valid;
        logic dp_write;
        logic [11:0] dp_addr;
        logic rd_wait;
        logic [31:0] hrdata;
    } mpwm_state_t;

endpackage

//--- rtl/mpwm_top.sv
// Purpose: multichannel pwm generator with global update and synchronised restart
// Assumes: ahb-lite slave, single word transfers; ext_clk_i asynchronous
// Notes: pwm sources are tick enables inside the one clock domain
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // pwm tick sources
    input wire logic periph_tick_i,
    input wire logic ext_clk_i,
    // pins
    output logic [`MPWM_NCH-1:0] pin_default_o,
    output logic [`MPWM_NCH-1:0] pin_default_oe_o,
    output logic [`MPWM_NSHARE-1:0] pin_alt_o,
    output logic [`MPWM_NSHARE-1:0] pin_alt_oe_o,
    output logic [`MPWM_NCH-1:0] chan_running_o
);

    mpwm_pkg::mpwm_state_t s_r;
    mpwm_pkg::mpwm_state_t s_nxt;
    mpwm_pkg::mpwm_ahb_req_t req;
    mpwm_pkg::mpwm_ahb_rsp_t rsp;
    logic [`MPWM_NCH-1:0] run;

    // high while the position sits inside the spread pulse of its slot
    function automatic logic slot_high(input logic [`MPWM_CNT_W-1:0] p,
                                       input logic [`MPWM_DUTY_W-1:0] d,
                                       input logic s32);
        logic [11:0] lim;
        logic hi;
        lim = 12'h000;
        hi = 1'b0;
        if (s32) begin
            // slot of 128 ticks, remainder spread over the first slots
            lim = {4'h0, d[12:5]} + {11'h000, (p[11:7] < d[4:0])}; // RL2
            hi = {5'h00, p[6:0]} < lim;
        end else begin
            // slot of 1024 ticks
            lim = {1'b0, d[12:2]} + {11'h000, (p[11:10] < d[1:0])};
            hi = {2'h0, p[9:0]} < lim;
        end
        return hi;
    endfunction

    // channel tick from its selected source
    function automatic logic src_tick(input logic [1:0] sel, input logic per, input logic ext);
        logic t;
        t = 1'b0;
        if (sel == `MPWM_CLK_CORE) begin
            t = 1'b1; // RL4
        end else if (sel == `MPWM_CLK_PERIPH) begin
            t = per; // RL4
        end else if (sel == `MPWM_CLK_EXT) begin
            t = ext; // RL4
        end
        return t;
    endfunction

    always_comb begin
        req.htrans = htrans_i;
        req.haddr = haddr_i;
        req.hwrite = hwrite_i;
        req.hsize = hsize_i;
        req.hwdata = hwdata_i;
        req.hsel = hsel_i;
        req.hready = hready_i;
    end

    always_comb begin
        for (int i = 0; i < `MPWM_NCH; i++) begin
            run[i] = s_r.master_en & s_r.cfg[i].en; // RL7
        end
    end

    // reads get one wait state because the read data is registered in s_r.hrdata before it is driven
    always_comb begin
        rsp.hrdata = s_r.hrdata;
        rsp.hreadyout = !(s_r.dp_valid && !s_r.dp_write && !s_r.rd_wait);
        rsp.hresp = 1'b0;
    end

    always_comb begin
        logic [31:0] rd;
        logic [`MPWM_NCH-1:0] restart;
        logic [3:0] ch;
        logic [3:0] sub;
        logic ext_rise;
        logic [`MPWM_CNT_W-1:0] pos;
        logic wave;
        rd = 32'h0000_0000;
        restart = '0;
        ch = s_r.dp_addr[7:4];
        sub = s_r.dp_addr[3:0];
        ext_rise = 1'b0;
        pos = '0;
        wave = 1'b0;
        s_nxt = s_r;
        s_nxt.upd = 1'b0; // RL10

        // external source: two flops, then edge detect on later stages
        s_nxt.ext_s1 = ext_clk_i;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_s3 = s_r.ext_s2;
        ext_rise = s_r.ext_s2 & ~s_r.ext_s3;

        // data phase
        if (s_r.dp_valid && s_r.dp_write) begin
            if (s_r.dp_addr == `MPWM_OFF_CTRL) begin
                s_nxt.master_en = hwdata_i[`MPWM_CTRL_MEN]; // RL8
                s_nxt.upd = hwdata_i[`MPWM_CTRL_UPD]; // RL10
            end else if (s_r.dp_addr == `MPWM_OFF_SYNC) begin
                s_nxt.sync_mask = hwdata_i[`MPWM_NCH-1:0];
                restart = hwdata_i[`MPWM_NCH-1:0]; // RL11
            end else if (s_r.dp_addr >= `MPWM_OFF_CH_BASE && s_r.dp_addr < `MPWM_OFF_CH_END) begin
                if (sub == `MPWM_CH_CFG) begin
                    s_nxt.cfg[ch].en = hwdata_i[`MPWM_CFG_EN];
                    s_nxt.cfg[ch].inv = hwdata_i[`MPWM_CFG_INV];
                    s_nxt.cfg[ch].reloc = hwdata_i[`MPWM_CFG_RELOC];
                    s_nxt.cfg[ch].clksel = hwdata_i[`MPWM_CFG_CLK_HI:`MPWM_CFG_CLK_LO];
                end else if (sub == `MPWM_CH_DUTY) begin
                    s_nxt.duty_pend[ch] = hwdata_i[`MPWM_DUTY_W-1:0]; // RL9
                end else if (sub == `MPWM_CH_DELAY) begin
                    s_nxt.dly[ch] = hwdata_i[`MPWM_CNT_W-1:0]; // RL12
                end else if (sub == `MPWM_CH_SPREAD) begin
                    // other values leave the setting as it was
                    if (hwdata_i[5:0] == `MPWM_SPREAD_4 && hwdata_i[31:6] == 26'h0) begin
                        s_nxt.cfg[ch].s32 = 1'b0; // RL3
                    end else if (hwdata_i[5:0] == `MPWM_SPREAD_32 && hwdata_i[31:6] == 26'h0) begin
                        s_nxt.cfg[ch].s32 = 1'b1; // RL3
                    end
                end
            end
        end else if (s_r.dp_valid && !s_r.rd_wait) begin
            if (s_r.dp_addr == `MPWM_OFF_CTRL) begin
                rd[`MPWM_CTRL_MEN] = s_r.master_en;
                rd[`MPWM_CTRL_UPD] = s_r.upd;
            end else if (s_r.dp_addr == `MPWM_OFF_SYNC) begin
                rd[`MPWM_NCH-1:0] = s_r.sync_mask;
            end else if (s_r.dp_addr == `MPWM_OFF_STAT) begin
                rd[`MPWM_NCH-1:0] = run;
            end else if (s_r.dp_addr >= `MPWM_OFF_CH_BASE && s_r.dp_addr < `MPWM_OFF_CH_END) begin
                if (sub == `MPWM_CH_CFG) begin
                    rd[`MPWM_CFG_EN] = s_r.cfg[ch].en;
                    rd[`MPWM_CFG_INV] = s_r.cfg[ch].inv;
                    rd[`MPWM_CFG_RELOC] = s_r.cfg[ch].reloc;
                    rd[`MPWM_CFG_CLK_HI:`MPWM_CFG_CLK_LO] = s_r.cfg[ch].clksel;
                end else if (sub == `MPWM_CH_DUTY) begin
                    rd[`MPWM_DUTY_W-1:0] = s_r.duty_pend[ch];
                end else if (sub == `MPWM_CH_DELAY) begin
                    rd[`MPWM_CNT_W-1:0] = s_r.dly[ch];
                end else if (sub == `MPWM_CH_SPREAD) begin
                    rd[5:0] = s_r.cfg[ch].s32 ? `MPWM_SPREAD_32 : `MPWM_SPREAD_4;
                end
            end
            s_nxt.hrdata = rd;
            s_nxt.rd_wait = 1'b1;
        end

        // address phase
        if (rsp.hreadyout) begin
            if (req.hsel && req.hready && req.htrans[1]) begin
                s_nxt.dp_valid = 1'b1;
                s_nxt.dp_write = req.hwrite;
                s_nxt.dp_addr = {req.haddr[11:2], 2'b00};
                s_nxt.rd_wait = 1'b0;
            end else if (req.hready) begin
                s_nxt.dp_valid = 1'b0;
                s_nxt.rd_wait = 1'b0;
            end
        end

        // channels
        for (int i = 0; i < `MPWM_NCH; i++) begin
            if (!run[i] || restart[i]) begin
                s_nxt.cnt[i] = '0; // RL11 RL17
            end else if (src_tick(s_r.cfg[i].clksel, periph_tick_i, ext_rise)) begin
                s_nxt.cnt[i] = s_r.cnt[i] + 12'h001; // RL1
            end
            if (s_r.upd) begin
                s_nxt.duty_act[i] = s_r.duty_pend[i]; // RL10 RL13
            end
            pos = s_r.cnt[i] - s_r.dly[i]; // RL12 RL17
            wave = run[i] & slot_high(pos, s_r.duty_act[i], s_r.cfg[i].s32); // RL7
            wave = wave ^ s_r.cfg[i].inv; // RL5
            if (i < `MPWM_NSHARE) begin
                s_nxt.pin_def[i] = run[i] & ~s_r.cfg[i].reloc & wave; // RL6
                s_nxt.pin_alt[3'(i)] = run[i] & s_r.cfg[i].reloc & wave; // RL6
            end else begin
                s_nxt.pin_def[i] = run[i] & wave;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
            for (int i = 0; i < `MPWM_NCH; i++) begin
                s_r.cfg[i].s32 <= `MPWM_RST_S32;
                s_r.duty_pend[i] <= `MPWM_RST_DUTY;
                s_r.duty_act[i] <= `MPWM_RST_DUTY;
                s_r.dly[i] <= `MPWM_RST_DELAY;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // a relocated shared channel releases the dac pin
    always_comb begin
        pin_default_oe_o = run;
        pin_alt_oe_o = '0;
        for (int i = 0; i < `MPWM_NSHARE; i++) begin
            pin_default_oe_o[i] = run[i] & ~s_r.cfg[i].reloc; // RL6
            pin_alt_oe_o[i] = run[i] & s_r.cfg[i].reloc; // RL6
        end
    end

    assign pin_default_o = s_r.pin_def;
    assign pin_alt_o = s_r.pin_alt;
    assign chan_running_o = run;
    assign hrdata_o = rsp.hrdata;
    assign hreadyout_o = rsp.hreadyout;
    assign hresp_o = rsp.hresp;

endmodule
